// ---- src/beat_fifo.sv ----
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0]    wr_q;           // Write index
  logic [AW-1:0]    rd_q;           // Read index
  logic [AW:0]      cnt_q;          // Fill level
  logic             push;
  logic             pop;

  // ==========================================================
  // Handshake
  // Full compare at counter width; DEPTH does not fit in AW bits
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- src/dma_ext_channel.sv ----
// Four-channel DMA extended-mode engine with APB registers
// Notes on behaviour
// [R1] Size codes: 00 byte8, 01 word16, 11 byte16
// [R2] Software never writes reserved size 10
// [R3] Byte8: any address, count is bytes minus one
// [R4] Word16: software loads even address shifted right
// [R5] Word16: count is words minus one
// [R6] Word16: pages unshifted, low page bit ignored
// [R7] Byte16 odd start: partial first/last transfers
// [R8] Byte16: address steps by two per cycle
// [R9] Byte16: count drops by bytes moved
// [R10] Bytes assembled so any memory width works
// [R11] Byte16 meant for 16-bit slaves, even starts
// [R12] Low two bits pick channel for upper six
// [R13] Reset sets timing field to compatible 00
// [R14] Write touches only the selected channel
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dma_ext_channel #(
  parameter int CHANNELS   = 4,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] src_data,
  input  wire logic        src_valid,
  output logic             src_ready,
  output logic             dst_valid,
  input  wire logic        dst_ready,
  output logic      [23:0] dst_addr,
  output logic      [15:0] dst_data,
  output logic      [1:0]  dst_byte_en,
  output logic             xfer_busy,
  output logic             xfer_done
);
  import xmode_pkg::*;

  // ==========================================================
  // Register state
  logic [5:0]  upper_q [CHANNELS];  // Per-channel bits 7:2
  logic [15:0] start_q;             // Programmed start address
  logic [15:0] count_q;             // Programmed count minus one
  logic [15:0] page_q;              // High page 15:8, low page 7:0
  logic        dec_q;               // Decrement direction
  logic [1:0]  chan_q;              // Channel running
  logic [1:0]  rdsel_q;             // Channel shown by readback
  logic [15:0] addr_q;              // Live address
  logic [16:0] remain_q;            // Bytes/words left minus one
  state_type   state_q;
  logic        done_q;
  logic        wr_en;
  logic        rd_en;
  logic        go;
  size_type    size_now;

  // ==========================================================
  // APB slave: zero wait states, error on unmapped
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign go     = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_GO]
                  && (state_q == ST_IDLE);
  assign pslverr = psel && penable &&
    !(paddr == ADDR_EXT_MODE || paddr == ADDR_CH_CFG ||
      paddr == ADDR_START || paddr == ADDR_COUNT ||
      paddr == ADDR_PAGE || paddr == ADDR_CTRL ||
      paddr == ADDR_STATUS || paddr == ADDR_CUR_ADDR);

  // Extended mode write: select in low bits, data above
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        upper_q[i] <= UPPER_RESET;  // [R13]
      end
    end else if (wr_en && paddr == ADDR_EXT_MODE) begin
      // Only the addressed channel changes [R12] [R14]
      upper_q[pwdata[SEL_MSB:SEL_LSB]] <= pwdata[UPPER_MSB:UPPER_LSB];
    end
  end

  // Plain programming registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_q <= 16'h0000;
      count_q <= 16'h0000;
      page_q  <= 16'h0000;
      dec_q   <= 1'b0;
      chan_q  <= 2'h0;
      rdsel_q <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_START: start_q <= pwdata[15:0];  // [R3] [R4]
        ADDR_COUNT: count_q <= pwdata[15:0];
        ADDR_PAGE:  page_q  <= pwdata[15:0];
        ADDR_CH_CFG: rdsel_q <= pwdata[1:0];
        ADDR_CTRL: begin
          if (state_q == ST_IDLE) begin
            dec_q  <= pwdata[CTRL_DEC];
            chan_q <= pwdata[CTRL_CH_MSB:CTRL_CH_LSB];
          end
        end
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        ADDR_CH_CFG:   prdata = {24'h0, upper_q[rdsel_q], rdsel_q};
        ADDR_START:    prdata = {16'h0, start_q};
        ADDR_COUNT:    prdata = {16'h0, count_q};
        ADDR_PAGE:     prdata = {16'h0, page_q};
        ADDR_CTRL:     prdata = {26'h0, chan_q, 2'h0, dec_q, 1'b0};
        ADDR_STATUS:   prdata = {14'h0, remain_q, done_q};
        ADDR_CUR_ADDR: prdata = {16'h0, addr_q};
        default:       prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Transfer engine
  assign size_now = size_type'(upper_q[chan_q][SIZE_MSB-UPPER_LSB:
                                               SIZE_LSB-UPPER_LSB]);

  // Beat formation
  logic        fifo_in_ready;
  logic        beat_fire;
  logic [1:0]  beat_be;
  logic [23:0] beat_addr;
  logic        last_beat;
  logic        odd_addr;

  assign odd_addr  = addr_q[0];
  assign beat_fire = (state_q == ST_RUN) && src_valid && fifo_in_ready;
  assign src_ready = (state_q == ST_RUN) && fifo_in_ready;

  // Lanes and bus address per mode; low page sits above the address
  // High page lies beyond the 24-bit bus and is only kept for readback
  always_comb begin
    beat_be   = 2'b01;
    beat_addr = {page_q[7:0], addr_q};
    last_beat = (remain_q == 17'h0);
    case (size_now)  // [R1]
      SIZE_BYTE8: begin
        // One byte per cycle, lane follows address [R3] [R10]
        beat_be   = odd_addr ? 2'b10 : 2'b01;
        beat_addr = {page_q[7:0], addr_q};
        last_beat = (remain_q == 17'h0);
      end
      SIZE_WORD16: begin
        // Address shifted, low page bit dropped [R6]
        beat_be   = 2'b11;
        beat_addr = {page_q[7:1], addr_q, 1'b0};
        last_beat = (remain_q == 17'h0);  // [R5]
      end
      SIZE_BYTE16: begin
        // Partial word at odd start or single byte end [R7] [R11]
        if (odd_addr) begin
          beat_be = 2'b10;
        end else if (remain_q == 17'h0) begin
          beat_be = 2'b01;
        end else begin
          beat_be = 2'b11;
        end
        // Word cycle on the even boundary, lanes pick the bytes
        beat_addr = {page_q[7:0], addr_q[15:1], 1'b0};
        // Odd partial with bytes left never ends the run [R9]
        last_beat = (remain_q == 17'h0) ||
                    (!odd_addr && remain_q == 17'h1);
      end
      default: begin
        // Reserved code: byte-mode address and count, always low lane [R2]
        beat_be   = 2'b01;
        beat_addr = {page_q[7:0], addr_q};
        last_beat = (remain_q == 17'h0);
      end
    endcase
  end

  // Address and count stepping
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_q   <= 16'h0000;
      remain_q <= 17'h00000;
    end else if (go) begin
      addr_q   <= start_q;
      remain_q <= {1'b0, count_q};  // [R3] [R5] [R9]
    end else if (beat_fire) begin
      if (size_now == SIZE_BYTE16) begin
        // Step by two from the word boundary; odd start realigns [R8]
        if (odd_addr) begin
          addr_q <= dec_q ? {addr_q[15:1], 1'b0} - STEP_TWO
                          : {addr_q[15:1], 1'b0} + STEP_TWO;
        end else begin
          addr_q <= dec_q ? addr_q - STEP_TWO : addr_q + STEP_TWO;
        end
        // Count drops by bytes moved [R9]
        if (beat_be == 2'b11) begin
          remain_q <= remain_q - 17'h2;
        end else begin
          remain_q <= remain_q - 17'h1;
        end
      end else begin
        addr_q   <= dec_q ? addr_q - STEP_ONE : addr_q + STEP_ONE;
        remain_q <= remain_q - 17'h1;
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      done_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_RUN;
            done_q  <= 1'b0;
          end
        end
        ST_RUN: begin
          if (beat_fire && last_beat) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!dst_valid) begin
            state_q <= ST_IDLE;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Output buffer: address, lanes and data
  logic [41:0] fifo_in;
  logic [41:0] fifo_out;
  logic [15:0] lane_data;

  // Odd byte goes to the high lane [R10]
  assign lane_data = (beat_be == 2'b10) ? {src_data[7:0], 8'h00}
                                        : src_data;
  assign fifo_in   = {beat_addr, beat_be, lane_data};

  beat_fifo #(
    .WIDTH (42),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (beat_fire),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (dst_valid),
    .out_ready (dst_ready),
    .out_data  (fifo_out)
  );

  assign dst_addr    = fifo_out[41:18];
  assign dst_byte_en = fifo_out[17:16];
  assign dst_data    = fifo_out[15:0];
  assign xfer_busy   = (state_q != ST_IDLE);
  assign xfer_done   = done_q;

  // ==========================================================
  // Checks
  // Timing field of channel 0 is compatible right after reset
  chk_reset_timing: assert property (@(posedge clk) // [R13]
    $rose(resetn) |-> upper_q[0][TIME_MSB-UPPER_LSB:TIME_LSB-UPPER_LSB]
                      == TIMING_COMPAT)
    else $error("timing not compatible after reset");
  // Mode write to another channel leaves channel 0 alone
  chk_sel_only: assert property (@(posedge clk) // [R14]
    disable iff (!resetn)
    wr_en && paddr == ADDR_EXT_MODE && pwdata[1:0] != 2'h0
      |=> $stable(upper_q[0]))
    else $error("unselected channel changed");
  // Mode write to channel 1 stores the upper six bits
  chk_sel_write: assert property (@(posedge clk) // [R12]
    disable iff (!resetn)
    wr_en && paddr == ADDR_EXT_MODE && pwdata[1:0] == 2'h1
      |=> upper_q[1] == $past(pwdata[7:2]))
    else $error("selected channel not written");
  // Even byte16 beat moves the address up by two
  chk_step_two: assert property (@(posedge clk) // [R8]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_BYTE16 && !odd_addr && !dec_q
      |=> addr_q == $past(addr_q) + STEP_TWO)
    else $error("byte16 address step wrong");
  // Odd byte16 beat realigns and still steps by two
  chk_odd_step: assert property (@(posedge clk) // [R8]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_BYTE16 && odd_addr && !dec_q
      |=> addr_q == {$past(addr_q[15:1]), 1'b0} + STEP_TWO)
    else $error("byte16 odd address step wrong");
  // Full word drops the count by two
  chk_count_bytes: assert property (@(posedge clk) // [R9]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_BYTE16 && beat_be == 2'b11
      |=> remain_q == $past(remain_q) - 17'h2)
    else $error("byte16 count not reduced by two");
  // Single byte drops the count by one
  chk_count_one: assert property (@(posedge clk) // [R9]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_BYTE16 && beat_be != 2'b11
      |=> remain_q == $past(remain_q) - 17'h1)
    else $error("byte16 count not reduced by one");
  // Odd byte16 address with bytes left is not the last beat
  chk_odd_tail: assert property (@(posedge clk) // [R9]
    disable iff (!resetn)
    state_q == ST_RUN && size_now == SIZE_BYTE16 && odd_addr
      && remain_q != 17'h0 |-> !last_beat)
    else $error("odd partial ended transfer early");
  // Odd byte16 address uses the high lane only
  chk_odd_partial: assert property (@(posedge clk) // [R7]
    disable iff (!resetn)
    state_q == ST_RUN && size_now == SIZE_BYTE16 && odd_addr
      |-> beat_be == 2'b10)
    else $error("odd start not partial");
  // Word mode drives the address one bit up, bit 0 low
  chk_word_lsb: assert property (@(posedge clk) // [R6]
    disable iff (!resetn)
    state_q == ST_RUN && size_now == SIZE_WORD16
      |-> beat_addr[8] == addr_q[7] && beat_addr[0] == 1'b0)
    else $error("word address not shifted");
  // Byte mode moves one byte and one address per beat
  chk_byte_step: assert property (@(posedge clk) // [R3]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_BYTE8 && !dec_q
      |=> addr_q == $past(addr_q) + STEP_ONE
          && remain_q == $past(remain_q) - 17'h1)
    else $error("byte mode step wrong");
  // Start loads the programmed count and enters the run state
  chk_load_count: assert property (@(posedge clk) // [R3] [R5]
    disable iff (!resetn)
    go |=> remain_q == {1'b0, $past(count_q)} ##0 state_q == ST_RUN)
    else $error("count not loaded");
  // Word mode counts one per beat
  chk_word_step: assert property (@(posedge clk) // [R5] [R1]
    disable iff (!resetn)
    beat_fire && size_now == SIZE_WORD16 && !dec_q
      |=> remain_q == $past(remain_q) - 17'h1)
    else $error("word count step wrong");
endmodule

// ---- src/xmode_pkg.sv ----
// Constants and types for the extended-mode DMA channel block
package xmode_pkg;
  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [11:0] ADDR_EXT_MODE  = 12'h000; // Write-only mode
  localparam logic [11:0] ADDR_CH_CFG    = 12'h004; // Readback of channel
  localparam logic [11:0] ADDR_START     = 12'h008; // Start address
  localparam logic [11:0] ADDR_COUNT     = 12'h00C; // Count minus one
  localparam logic [11:0] ADDR_PAGE      = 12'h010; // Low/high page
  localparam logic [11:0] ADDR_CTRL      = 12'h014; // Go / direction
  localparam logic [11:0] ADDR_STATUS    = 12'h018; // Done / remaining
  localparam logic [11:0] ADDR_CUR_ADDR  = 12'h01C; // Live address
  // ==========================================================
  // Field layout of the mode byte
  localparam int SEL_LSB   = 0;
  localparam int SEL_MSB   = 1;
  localparam int SIZE_LSB  = 2;
  localparam int SIZE_MSB  = 3;
  localparam int TIME_LSB  = 4;
  localparam int TIME_MSB  = 5;
  localparam int UPPER_LSB = 2;
  localparam int UPPER_MSB = 7;
  localparam logic [5:0] UPPER_RESET = 6'h00; // Compatible timing, 8-bit
  localparam logic [1:0] TIMING_COMPAT = 2'h0;
  // CTRL bits
  localparam int CTRL_GO  = 0;
  localparam int CTRL_DEC = 1;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_CH_MSB = 5;
  // Address steps
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  // ==========================================================
  // Transfer size codes
  typedef enum logic [1:0] {
    SIZE_BYTE8   = 2'b00,
    SIZE_WORD16  = 2'b01,
    SIZE_RSVD    = 2'b10,
    SIZE_BYTE16  = 2'b11
  } size_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10
  } state_type;
endpackage

// ---- tb/dma_channel_extended_mode_test.sv ----
// Self-checking bench for the extended-mode DMA channel block
`timescale 1ns/1ps
module dma_channel_extended_mode_test;
  import xmode_pkg::*;
  logic        clk, resetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [15:0] src_data, dst_data;
  logic        src_valid, src_ready, dst_valid, dst_ready;
  logic [23:0] dst_addr;
  logic [1:0]  dst_byte_en;
  logic        xfer_busy, xfer_done;
  int          bad_count, n_tests, b0, s0;
  logic [5:0]  up [4]; // Upper-field pattern per channel
  logic [7:0]  lane_byte; // Byte taken from its lane

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dma_ext_channel i_dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
    .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_addr(dst_addr),
    .dst_data(dst_data), .dst_byte_en(dst_byte_en),
    .xfer_busy(xfer_busy), .xfer_done(xfer_done));

  dma_far_side i_far (.clk(clk), .resetn(resetn), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready), .dst_valid(dst_valid),
    .dst_ready(dst_ready), .dst_addr(dst_addr), .dst_data(dst_data),
    .dst_byte_en(dst_byte_en));

  // ==========================================================
  // Compare, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // Program a channel, start it and wait for completion
  task automatic xfer(input logic [1:0] size, input logic dec,
    input logic [1:0] ch, input logic [15:0] st, cnt, pg, input int nb);
    int n;
    n = 0;
    apb(1'b1, ADDR_EXT_MODE, {24'h0, 2'b00, TIMING_COMPAT, size, ch});
    apb(1'b1, ADDR_START, {16'h0, st});
    apb(1'b1, ADDR_COUNT, {16'h0, cnt});
    apb(1'b1, ADDR_PAGE, {16'h0, pg});
    b0 = i_far.n_dst;
    s0 = i_far.n_src;
    apb(1'b1, ADDR_CTRL, {26'h0, ch, 2'b00, dec, 1'b1});
    do begin
      @(posedge clk);
      n++;
    end while (!(xfer_done === 1'b1 && xfer_busy === 1'b0) && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      print_verdict();
    end
    check(i_far.n_dst - b0, nb);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    bad_count = 0;
    n_tests   = 0;
    resetn    = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    up        = '{6'h3D, 6'h2B, 6'h14, 6'h0F};
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // Upper fields clear after reset
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_CH_CFG, 32'(c));
      apb(1'b0, ADDR_CH_CFG, 32'h0);
      check(rd, 32'(c));
    end
    apb(1'b0, ADDR_EXT_MODE, 32'h0);
    check(rd, 32'h0);
    // Per-channel writes, one rewrite, one unmapped write
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_EXT_MODE, {24'h0, up[c], 2'(c)});
    end
    apb(1'b1, ADDR_EXT_MODE, {24'h0, 6'h07, 2'b10});
    up[2] = 6'h07;
    apb(1'b1, 12'h020, 32'hFF);
    check({31'h0, err}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_CH_CFG, 32'(c));
      apb(1'b0, ADDR_CH_CFG, 32'h0);
      check(rd, {24'h0, up[c], 2'(c)});
    end
    // Byte mode from an odd address, three bytes
    xfer(SIZE_BYTE8, 1'b0, 2'd0, 16'h00FF, 16'h0002, 16'h0012, 3);
    for (int i = 0; i < 3; i++) begin
      check(i_far.got_addr[b0+i], {8'h12, 16'h00FF + 16'(i)});
      // Odd addresses (i even here) ride the high lane
      check(i_far.got_be[b0+i], i[0] ? 2'b01 : 2'b10);
      lane_byte = i[0] ? i_far.got_data[b0+i][7:0]
                       : i_far.got_data[b0+i][15:8];
      check(lane_byte, 8'h30 + 8'(s0 + i));
    end
    // Word mode: even target 2468 loaded shifted, odd low page
    xfer(SIZE_WORD16, 1'b0, 2'd1, 16'h1234, 16'h0001, 16'h7735, 2);
    for (int i = 0; i < 2; i++) begin
      check(i_far.got_addr[b0+i], {7'h1A, 16'h1234 + 16'(i), 1'b0});
      check(i_far.got_be[b0+i], 2'b11);
      check(i_far.got_data[b0+i][7:0], 8'h30 + 8'(s0 + i));
    end
    // 16-bit byte mode, odd start: partial first and last
    xfer(SIZE_BYTE16, 1'b0, 2'd3, 16'h0101, 16'h0003, 16'h0056, 3);
    check(i_far.got_be[b0], 2'b10);
    check(i_far.got_be[b0+1], 2'b11);
    check(i_far.got_be[b0+2], 2'b01);
    for (int i = 1; i < 3; i++) begin
      check(i_far.got_addr[b0+i] - i_far.got_addr[b0+i-1], 24'h2);
    end
    // 16-bit byte mode, even start, decrementing
    xfer(SIZE_BYTE16, 1'b1, 2'd2, 16'h0200, 16'h0003, 16'h0056, 2);
    check(i_far.got_be[b0], 2'b11);
    check(i_far.got_be[b0+1], 2'b11);
    check(i_far.got_addr[b0] - i_far.got_addr[b0+1], 24'h2);
    print_verdict();
  end
endmodule

// ---- tb/dma_far_side.sv ----
// Far-side model: 16-bit DMA slave source and a stalling sink
`timescale 1ns/1ps
module dma_far_side (
  input  wire logic        clk,
  input  wire logic        resetn,
  output logic      [15:0] src_data,
  output logic             src_valid,
  input  wire logic        src_ready,
  input  wire logic        dst_valid,
  output logic             dst_ready,
  input  wire logic [23:0] dst_addr,
  input  wire logic [15:0] dst_data,
  input  wire logic [1:0]  dst_byte_en
);
  int          cyc;           // Free-running stall pacer
  int          n_src;         // Source beats taken
  int          n_dst;         // Sink beats accepted
  logic [23:0] got_addr [64]; // Captured sink addresses
  logic [15:0] got_data [64]; // Captured sink data
  logic [1:0]  got_be   [64]; // Captured byte lanes
  logic [7:0]  nk;            // Low byte of the next source beat

  assign nk = 8'h30 + n_src[7:0] + {7'h0, src_valid & src_ready};

  // ==========================================================
  // Source: full 16-bit slave, idles every third cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cyc       <= 0;
      n_src     <= 0;
      src_valid <= 1'b0;
      src_data  <= 16'h0000;
    end else begin
      cyc <= cyc + 1;
      if (src_valid && src_ready) begin
        n_src <= n_src + 1;
      end
      // Offer held until taken; idle data is scrambled
      if (!src_valid || src_ready) begin
        src_valid <= (cyc % 3 != 0);
        src_data  <= (cyc % 3 != 0) ? {~nk, nk} : ~src_data;
      end
    end
  end

  // ==========================================================
  // Sink: stalls one cycle in four, records accepted beats
  always_ff @(posedge clk) begin
    if (!resetn) begin
      n_dst     <= 0;
      dst_ready <= 1'b0;
    end else begin
      dst_ready <= (cyc % 4 != 1);
      if (dst_valid && dst_ready) begin
        got_addr[n_dst] <= dst_addr;
        got_data[n_dst] <= dst_data;
        got_be[n_dst]   <= dst_byte_en;
        n_dst           <= n_dst + 1;
      end
    end
  end
endmodule
